// file: hdl/weld_alarm_monitor.sv
// weld_alarm_monitor: compares live measurements against limits and
// keeps sticky alarm words for overload, cutoff and setup groups.
// assumes measurements are synchronous unsigned samples on clk_i and
// that the sequencer pulses weld_start_i and holds weld/brake levels.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module weld_alarm_monitor
    import weld_alarm_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire logic          powerup_i,
    input  wire logic          strap_short_i,
    input  wire logic          weld_active_i,
    input  wire logic          weld_start_i,
    input  wire logic          brake_active_i,
    input  wire logic          sonics_on_i,
    input  wire logic          phase_out_i,
    input  wire logic [DW-1:0] current_i,
    input  wire logic [DW-1:0] current_peak_i,
    input  wire logic [DW-1:0] freq_i,
    input  wire logic [DW-1:0] power_i,
    input  wire logic [DW-1:0] power_peak_i,
    input  wire logic [DW-1:0] voltage_i,
    input  wire logic [DW-1:0] voltage_peak_i,
    input  wire logic [DW-1:0] temp_i,
    input  wire logic [DW-1:0] energy_step_i,
    input  wire logic [DW-1:0] cust1_i,
    input  wire logic [DW-1:0] cust2_i,
    input  wire logic          preset_recall_i,
    input  wire logic [5:0]    preset_num_i,
    input  wire logic [7:0]    addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [31:0]   rdata_o,
    output logic               sonics_off_o,
    output logic               cycle_abort_o,
    output logic               cold_start_o,
    output logic               preset_valid_o
);
    typedef struct packed {
        logic [31:0]   ovl;
        logic [31:0]   cut;
        logic [31:0]   setf;
        logic [15:0]   phase_lim;
        logic [15:0]   phase_time;
        logic [15:0]   freq_low;
        logic [15:0]   freq_high;
        logic [15:0]   energy_cut;
        logic [15:0]   power_cut;
        logic [15:0]   cust1_cut;
        logic [15:0]   cust2_cut;
        logic [15:0]   time_cut;
        logic [15:0]   freq_neg;
        logic [15:0]   freq_pos;
        logic [15:0]   amplitude;
        logic [15:0]   net_addr;
        logic [1:0]    cust_ena;
        logic [15:0]   phase_cnt;
        logic [31:0]   energy_acc;
        logic [31:0]   son_time;
        logic [DW-1:0] start_freq;
        phase_st_t     st;
        logic          sonics_off;
        logic          abort;
        logic          cold;
        logic          pwr_seen;
        logic          preset_ok;
        logic [31:0]   rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic weld_win;
    logic brk_win;
    logic [4:0] ovl_hit;   // phase, current, freq, power, voltage
    logic temp_hit;
    logic [8:0] cut_hit;
    logic [DW:0] f_low_bound;
    logic [DW:0] f_high_bound;

    // overload conditions shared between weld and brake phases
    always_comb begin
        weld_win   = weld_active_i && !brake_active_i;
        brk_win    = brake_active_i;
        ovl_hit[0] = phase_out_i && (cur.phase_cnt >= cur.phase_time);
        ovl_hit[1] = current_i >= current_peak_i;
        ovl_hit[2] = (freq_i < cur.freq_low) ||
                     (freq_i > cur.freq_high);
        ovl_hit[3] = power_i >= power_peak_i;
        ovl_hit[4] = voltage_i >= voltage_peak_i;
        temp_hit   = temp_i >= TEMP_LIMIT_RST;
        // widened so the offset cannot wrap
        f_low_bound  = {1'b0, freq_i} + {1'b0, cur.freq_neg};
        f_high_bound = {1'b0, cur.start_freq} + {1'b0, cur.freq_pos};
        cut_hit = '0;
        // start cycle skipped: references still hold the last weld
        if (weld_win && sonics_on_i && !weld_start_i) begin
            cut_hit[BIT_CUT_ENERGY] =
                cur.energy_acc > {16'h0000, cur.energy_cut};
            cut_hit[BIT_CUT_POWER] = power_i > cur.power_cut;
            cut_hit[BIT_CUT_CUST1] = cur.cust_ena[0] &&
                                     (cust1_i > cur.cust1_cut);
            cut_hit[BIT_CUT_CUST2] = cur.cust_ena[1] &&
                                     (cust2_i > cur.cust2_cut);
            cut_hit[BIT_CUT_TIME] =
                cur.son_time > {16'h0000, cur.time_cut};
            cut_hit[BIT_CUT_FLOW] =
                f_low_bound < {1'b0, cur.start_freq};
            cut_hit[BIT_CUT_FHIGH] =
                {1'b0, freq_i} > f_high_bound;
        end
    end

    // next-state logic for flags, settings and the cycle supervisor
    always_comb begin
        next_cur = cur;
        next_cur.rdata = 32'h0000_0000;
        next_cur.phase_cnt = (phase_out_i && (weld_win || brk_win)) ?
            ((cur.phase_cnt == 16'hFFFF) ? cur.phase_cnt :
             cur.phase_cnt + 16'h0001) : 16'h0000;

        // sticky flags; a clear write is applied first so a hit wins
        if (wr_i && addr_i == OFS_OVL_FLAGS)
            next_cur.ovl = cur.ovl & ~wdata_i;
        if (wr_i && addr_i == OFS_CUT_FLAGS)
            next_cur.cut = cur.cut & ~wdata_i;
        if (wr_i && addr_i == OFS_SET_FLAGS)
            next_cur.setf = cur.setf & ~wdata_i;

        // separate words per group keep equal bit positions distinct
        if (weld_win) begin
            for (int i = 0; i < 5; i++)
                if (ovl_hit[i])
                    next_cur.ovl[BIT_OVL_PHASE + i] = 1'b1;
        end
        if (brk_win) begin
            for (int i = 0; i < 5; i++)
                if (ovl_hit[i])
                    next_cur.ovl[BIT_BRK_BASE + i] = 1'b1;
        end
        if (temp_hit)
            next_cur.ovl[BIT_OVL_TEMP] = 1'b1;
        next_cur.cut = next_cur.cut | {23'h00_0000, cut_hit};

        // preset recall check
        next_cur.preset_ok = 1'b0;
        if (preset_recall_i) begin
            if (preset_num_i > PRESET_MAX)
                next_cur.setf[BIT_SET_PRESET] = 1'b1;
            else
                next_cur.preset_ok = 1'b1;
        end

        // weld start latches reference frequency and clears accumulators
        if (weld_start_i) begin
            next_cur.start_freq = freq_i;
            next_cur.energy_acc = 32'h0000_0000;
            next_cur.son_time   = 32'h0000_0000;
        end else if (weld_win && sonics_on_i) begin
            next_cur.energy_acc = cur.energy_acc + {16'h0000, energy_step_i};
            next_cur.son_time   = cur.son_time + 32'h0000_0001;
        end

        // supervisor: sonics are dropped on the edge after the hit, abort follows one cycle later
        case (cur.st)
            ST_IDLE: begin
                next_cur.sonics_off = 1'b0;
                next_cur.abort      = 1'b0;
                if (weld_start_i)
                    next_cur.st = ST_WELD;
            end
            ST_WELD: begin
                if ((|ovl_hit && weld_win) || temp_hit) begin
                    next_cur.sonics_off = 1'b1;
                    next_cur.st = ST_ABORT;
                end else if (|cut_hit) begin
                    next_cur.sonics_off = 1'b1;
                end
                if (brk_win)
                    next_cur.st = ST_BRAKE;
                if (!weld_active_i && !brk_win)
                    next_cur.st = ST_IDLE;
            end
            ST_BRAKE: begin
                if (!brk_win)
                    next_cur.st = ST_IDLE;
            end
            ST_ABORT: begin
                next_cur.abort = 1'b1;
                if (!weld_active_i)
                    next_cur.st = ST_IDLE;
            end
            default: next_cur.st = ST_IDLE;
        endcase

        // user settings writes
        if (wr_i) begin
            case (addr_i)
                OFS_PHASE_LIM:  next_cur.phase_lim  = wdata_i[15:0];
                OFS_PHASE_TIME: next_cur.phase_time = wdata_i[15:0];
                OFS_FREQ_LOW:   next_cur.freq_low   = wdata_i[15:0];
                OFS_FREQ_HIGH:  next_cur.freq_high  = wdata_i[15:0];
                OFS_ENERGY_CUT: next_cur.energy_cut = wdata_i[15:0];
                OFS_POWER_CUT:  next_cur.power_cut  = wdata_i[15:0];
                OFS_CUST1_CUT:  next_cur.cust1_cut  = wdata_i[15:0];
                OFS_CUST2_CUT:  next_cur.cust2_cut  = wdata_i[15:0];
                OFS_TIME_CUT:   next_cur.time_cut   = wdata_i[15:0];
                OFS_FREQ_NEG:   next_cur.freq_neg   = wdata_i[15:0];
                OFS_FREQ_POS:   next_cur.freq_pos   = wdata_i[15:0];
                OFS_AMPLITUDE:  next_cur.amplitude  = wdata_i[15:0];
                OFS_NET_ADDR:   next_cur.net_addr   = wdata_i[15:0];
                OFS_CUST_ENA:   next_cur.cust_ena   = wdata_i[1:0];
                default: ;
            endcase
        end

        // strap is sampled once, on the first power-up pulse only
        next_cur.cold = 1'b0;
        if (powerup_i && !cur.pwr_seen) begin
            next_cur.pwr_seen = 1'b1;
            if (strap_short_i) begin
                next_cur.cold       = 1'b1;
                next_cur.phase_lim  = DEF_PHASE_LIM;
                next_cur.phase_time = DEF_PHASE_TIME;
                next_cur.freq_low   = DEF_FREQ_LOW;
                next_cur.freq_high  = DEF_FREQ_HIGH;
                next_cur.energy_cut = DEF_ENERGY_CUT;
                next_cur.power_cut  = DEF_POWER_CUT;
                next_cur.cust1_cut  = DEF_CUST_CUT;
                next_cur.cust2_cut  = DEF_CUST_CUT;
                next_cur.time_cut   = DEF_TIME_CUT;
                next_cur.freq_neg   = DEF_FREQ_OFS;
                next_cur.freq_pos   = DEF_FREQ_OFS;
                next_cur.amplitude  = DEF_AMPLITUDE;
                next_cur.net_addr   = DEF_NET_ADDR;
                next_cur.cust_ena   = DEF_CUST_ENA;
                // version is a constant, never part of the restore
            end
        end

        // read mux; data lands one cycle after the strobe
        if (rd_i) begin
            case (addr_i)
                OFS_OVL_FLAGS:  next_cur.rdata = cur.ovl;
                OFS_CUT_FLAGS:  next_cur.rdata = cur.cut;
                OFS_SET_FLAGS:  next_cur.rdata = cur.setf;
                OFS_STATUS:     next_cur.rdata = {27'h000_0000, cur.pwr_seen,
                                    cur.abort, cur.sonics_off, cur.st};
                OFS_PHASE_LIM:  next_cur.rdata = {16'h0000, cur.phase_lim};
                OFS_PHASE_TIME: next_cur.rdata = {16'h0000, cur.phase_time};
                OFS_FREQ_LOW:   next_cur.rdata = {16'h0000, cur.freq_low};
                OFS_FREQ_HIGH:  next_cur.rdata = {16'h0000, cur.freq_high};
                OFS_ENERGY_CUT: next_cur.rdata = {16'h0000, cur.energy_cut};
                OFS_POWER_CUT:  next_cur.rdata = {16'h0000, cur.power_cut};
                OFS_CUST1_CUT:  next_cur.rdata = {16'h0000, cur.cust1_cut};
                OFS_CUST2_CUT:  next_cur.rdata = {16'h0000, cur.cust2_cut};
                OFS_TIME_CUT:   next_cur.rdata = {16'h0000, cur.time_cut};
                OFS_FREQ_NEG:   next_cur.rdata = {16'h0000, cur.freq_neg};
                OFS_FREQ_POS:   next_cur.rdata = {16'h0000, cur.freq_pos};
                OFS_AMPLITUDE:  next_cur.rdata = {16'h0000, cur.amplitude};
                OFS_NET_ADDR:   next_cur.rdata = {16'h0000, cur.net_addr};
                OFS_CUST_ENA:   next_cur.rdata = {30'h0000_0000, cur.cust_ena};
                OFS_VERSION:    next_cur.rdata = {16'h0000, VERSION_CODE};
                default:        next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register; settings reset to factory defaults
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cur            <= '0;
            cur.phase_lim  <= DEF_PHASE_LIM;
            cur.phase_time <= DEF_PHASE_TIME;
            cur.freq_low   <= DEF_FREQ_LOW;
            cur.freq_high  <= DEF_FREQ_HIGH;
            cur.energy_cut <= DEF_ENERGY_CUT;
            cur.power_cut  <= DEF_POWER_CUT;
            cur.cust1_cut  <= DEF_CUST_CUT;
            cur.cust2_cut  <= DEF_CUST_CUT;
            cur.time_cut   <= DEF_TIME_CUT;
            cur.freq_neg   <= DEF_FREQ_OFS;
            cur.freq_pos   <= DEF_FREQ_OFS;
            cur.amplitude  <= DEF_AMPLITUDE;
            cur.net_addr   <= DEF_NET_ADDR;
            cur.st         <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_o        = cur.rdata;
    assign sonics_off_o   = cur.sonics_off;
    assign cycle_abort_o  = cur.abort;
    assign cold_start_o   = cur.cold;
    assign preset_valid_o = cur.preset_ok;
endmodule

// file: hdl/weld_alarm_pkg.sv
// weld_alarm_pkg: constants shared by the weld alarm monitor.
// assumes a single 50 MHz clock and a plain strobe register port.
// How it works
// - overload alarm in weld: sonics off first, then abort the cycle
// - phase outside limit for limit time raises overload bit 1
// - current reaching peak limit in weld raises overload bit 2
// - power reaching peak limit in weld raises overload bit 4
// - voltage reaching peak limit in weld raises overload bit 5
// - heat sink at over-temperature threshold raises overload bit 6
// - same overloads during energy brake raise bits 17 to 21
// - cutoff alarm stops sonics but cycle continues
// - accumulated sonics-on energy above cutoff raises cutoff bit 2
// - peak sonics-on power above cutoff raises cutoff bit 3
// - custom analog inputs above cutoff raise cutoff bits 4 and 8
// - sonics-on time above maximum raises cutoff bit 5
// - frequency below start frequency minus offset raises cutoff bit 6
// - frequency above start frequency plus offset raises cutoff bit 7
// - recall of preset number above 32 raises setup bit 2
// - cold start restores all user settings to factory defaults
// - cold start leaves identity registers such as version untouched
// - strap shorted at power up triggers cold start; operator removes it
package weld_alarm_pkg;
    // register offsets
    localparam logic [7:0] OFS_OVL_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_CUT_FLAGS   = 8'h01;
    localparam logic [7:0] OFS_SET_FLAGS   = 8'h02;
    localparam logic [7:0] OFS_STATUS      = 8'h03;
    localparam logic [7:0] OFS_PHASE_LIM   = 8'h04;
    localparam logic [7:0] OFS_PHASE_TIME  = 8'h05;
    localparam logic [7:0] OFS_FREQ_LOW    = 8'h06;
    localparam logic [7:0] OFS_FREQ_HIGH   = 8'h07;
    localparam logic [7:0] OFS_ENERGY_CUT  = 8'h08;
    localparam logic [7:0] OFS_POWER_CUT   = 8'h09;
    localparam logic [7:0] OFS_CUST1_CUT   = 8'h0A;
    localparam logic [7:0] OFS_CUST2_CUT   = 8'h0B;
    localparam logic [7:0] OFS_TIME_CUT    = 8'h0C;
    localparam logic [7:0] OFS_FREQ_NEG    = 8'h0D;
    localparam logic [7:0] OFS_FREQ_POS    = 8'h0E;
    localparam logic [7:0] OFS_AMPLITUDE   = 8'h0F;
    localparam logic [7:0] OFS_NET_ADDR    = 8'h10;
    localparam logic [7:0] OFS_CUST_ENA    = 8'h11;
    localparam logic [7:0] OFS_VERSION     = 8'h12;

    // flag bit positions within group words
    localparam int BIT_OVL_PHASE  = 1;
    localparam int BIT_OVL_CURR   = 2;
    localparam int BIT_OVL_FREQ   = 3;
    localparam int BIT_OVL_POWER  = 4;
    localparam int BIT_OVL_VOLT   = 5;
    localparam int BIT_OVL_TEMP   = 6;
    localparam int BIT_BRK_BASE   = 17;
    localparam int BIT_CUT_ENERGY = 2;
    localparam int BIT_CUT_POWER  = 3;
    localparam int BIT_CUT_CUST1  = 4;
    localparam int BIT_CUT_TIME   = 5;
    localparam int BIT_CUT_FLOW   = 6;
    localparam int BIT_CUT_FHIGH  = 7;
    localparam int BIT_CUT_CUST2  = 8;
    localparam int BIT_SET_PRESET = 2;

    localparam logic [5:0] PRESET_MAX = 6'h20;      // 32

    // over-temperature threshold in tenths of a degree: 85.0 C
    localparam logic [15:0] TEMP_LIMIT_RST = 16'h0352;

    // factory defaults restored by cold start (values arbitrary)
    localparam logic [15:0] DEF_PHASE_LIM  = 16'h0010;
    localparam logic [15:0] DEF_PHASE_TIME = 16'h0064;
    localparam logic [15:0] DEF_FREQ_LOW   = 16'h4E20;
    localparam logic [15:0] DEF_FREQ_HIGH  = 16'h5208;
    localparam logic [15:0] DEF_ENERGY_CUT = 16'hFFFF;
    localparam logic [15:0] DEF_POWER_CUT  = 16'hFFFF;
    localparam logic [15:0] DEF_CUST_CUT   = 16'hFFFF;
    localparam logic [15:0] DEF_TIME_CUT   = 16'hFFFF;
    localparam logic [15:0] DEF_FREQ_OFS   = 16'h0064;
    localparam logic [15:0] DEF_AMPLITUDE  = 16'h0064;
    localparam logic [15:0] DEF_NET_ADDR   = 16'h0001;
    localparam logic [1:0]  DEF_CUST_ENA   = 2'h0;

    // firmware version code, value arbitrary
    localparam logic [15:0] VERSION_CODE   = 16'h0101;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WELD  = 2'b01,
        ST_BRAKE = 2'b10,
        ST_ABORT = 2'b11
    } phase_st_t;
endpackage

// file: tb/tb_weld_alarm_monitor.sv
// tb_weld_alarm_monitor: self-checking bench for the alarm monitor.
// assumes the stack model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_weld_alarm_monitor
    import weld_alarm_pkg::*;
;
    typedef struct {
        logic [3:0]  f;
        logic [7:0]  ofs;
        logic [15:0] val;
        int          ob;
        int          cb;
        int          ab;
        logic        bk;
    } case_t;
    localparam logic [7:0] NC = OFS_ENERGY_CUT;
    logic        clk_i = 1'b0, srst_i = 1'b1, powerup_i = 1'b0;
    logic        strap_short_i = 1'b0, weld_active_i = 1'b0;
    logic        weld_start_i = 1'b0, brake_active_i = 1'b0;
    logic        sonics_req = 1'b0, preset_recall_i = 1'b0;
    logic        wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
    logic [3:0]  fault = 4'h0;
    logic [5:0]  preset_num_i = 6'h00, pn;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000, rnd, rdata_o;
    logic [39:0] e, exp_q [$];
    logic        sonics_on_i, phase_out_i, sonics_off_o, cycle_abort_o;
    logic        cold_start_o, preset_valid_o;
    logic [15:0] current_i, freq_i, power_i, voltage_i, temp_i, peak;
    logic [15:0] energy_step_i, cust1_i, cust2_i;
    int          num_errors = 0, cmp_count = 0, cyc = 0;
    int          seed = 32'h592b;
    // fault code, cutoff register and value, overload bit, cutoff bit,
    // abort expectation (2 = not judged), brake phase
    case_t cases [17] = '{
        '{4'h1, NC, 16'hFFFF, 2, 0, 1, 1'b0},
        '{4'h2, NC, 16'hFFFF, 4, 0, 1, 1'b0},
        '{4'h3, NC, 16'hFFFF, 5, 0, 1, 1'b0},
        '{4'h4, NC, 16'hFFFF, 3, 6, 1, 1'b0},
        '{4'h5, NC, 16'hFFFF, 6, 0, 1, 1'b0},
        '{4'h6, NC, 16'hFFFF, 1, 0, 1, 1'b0},
        '{4'h7, OFS_POWER_CUT, 16'h0080, 0, 3, 0, 1'b0},
        '{4'h8, OFS_CUST1_CUT, 16'h0080, 0, 4, 0, 1'b0},
        '{4'h9, OFS_CUST2_CUT, 16'h0080, 0, 8, 0, 1'b0},
        '{4'hA, NC, 16'hFFFF, 0, 6, 0, 1'b0},
        '{4'hB, NC, 16'hFFFF, 0, 7, 0, 1'b0},
        '{4'h0, NC, 16'h0003, 0, 2, 0, 1'b0},
        '{4'h0, OFS_TIME_CUT, 16'h0003, 0, 5, 0, 1'b0},
        '{4'h1, NC, 16'hFFFF, 18, 0, 2, 1'b1},
        '{4'h2, NC, 16'hFFFF, 20, 0, 2, 1'b1},
        '{4'h3, NC, 16'hFFFF, 21, 0, 2, 1'b1},
        '{4'h6, NC, 16'hFFFF, 17, 0, 2, 1'b1}};

    weld_alarm_monitor #(.DW(16)) i_weld_alarm_monitor (.*,
        .current_peak_i(peak), .power_peak_i(peak),
        .voltage_peak_i(peak));
    weld_stack_model i_weld_stack_model (
        .req_i(sonics_req), .stop_i(sonics_off_o), .fault_i(fault),
        .sonics_on_o(sonics_on_i), .phase_out_o(phase_out_i),
        .current_o(current_i), .freq_o(freq_i), .power_o(power_i),
        .voltage_o(voltage_i), .temp_o(temp_i), .energy_o(energy_step_i),
        .cust1_o(cust1_i), .cust2_o(cust2_i), .peak_o(peak));

    always #10 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] x,
                           input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] reg %h exp %h got %h", a, x, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic x, input logic g);
        cmp_count++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %s exp %b got %b", n, x, g);
        end
    endtask
    // read answers stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk_reg(e[39:32], e[31:0], rdata_o);
        end
        rd_seen <= rd_i;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back({a, x});
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask
    // one weld with one fault
    task automatic run(input case_t c);
        int n;
        n = 0;
        wr(c.ofs, {16'h0000, c.val});
        @(posedge clk_i);
        weld_start_i  <= 1'b1;
        weld_active_i <= 1'b1;
        sonics_req    <= 1'b1;
        @(posedge clk_i);
        weld_start_i   <= 1'b0;
        fault          <= c.f;
        brake_active_i <= c.bk;
        while (sonics_off_o !== 1'b1 && n < 12) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
        if (!c.bk) chk_bit("sonics_off", 1'b1, sonics_off_o);
        if (c.ab == 1) chk_bit("abort", 1'b1, cycle_abort_o);
        if (c.ab == 0) chk_bit("abort", 1'b0, cycle_abort_o);
        fault          <= 4'h0;
        brake_active_i <= 1'b0;
        sonics_req     <= 1'b0;
        weld_active_i  <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(OFS_OVL_FLAGS, c.ob ? 32'h1 << c.ob : 32'h0);
        rd(OFS_CUT_FLAGS, c.cb ? 32'h1 << c.cb : 32'h0);
        wr(OFS_OVL_FLAGS, 32'hFFFF_FFFF);
        wr(OFS_CUT_FLAGS, 32'hFFFF_FFFF);
        wr(c.ofs, 32'h0000_FFFF);
        rd(OFS_OVL_FLAGS, 32'h0);
        rd(OFS_CUT_FLAGS, 32'h0);
    endtask

    initial begin
        strap_short_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        rnd = {16'h0000, 16'($random(seed))};
        wr(OFS_AMPLITUDE, rnd);
        wr(OFS_NET_ADDR, rnd);
        wr(OFS_VERSION, rnd);
        rd(OFS_AMPLITUDE, rnd);
        rd(OFS_VERSION, {16'h0000, VERSION_CODE});
        rd(8'h40, 32'h0);
        @(posedge clk_i);
        powerup_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk_bit("cold_start", 1'b1, cold_start_o);
        strap_short_i <= 1'b0;
        @(posedge clk_i);
        chk_bit("cold_start", 1'b0, cold_start_o);
        rd(OFS_AMPLITUDE, {16'h0000, DEF_AMPLITUDE});
        rd(OFS_NET_ADDR, {16'h0000, DEF_NET_ADDR});
        rd(OFS_VERSION, {16'h0000, VERSION_CODE});
        wr(OFS_PHASE_TIME, 32'h2);
        wr(OFS_CUST_ENA, 32'h3);
        foreach (cases[i]) run(cases[i]);
        for (int i = 0; i < 6; i++) begin
            pn = (i == 0) ? 6'h20 : (i == 1) ? 6'h21 : 6'($random(seed));
            @(posedge clk_i);
            preset_recall_i <= 1'b1;
            preset_num_i    <= pn;
            @(posedge clk_i);
            preset_recall_i <= 1'b0;
            @(posedge clk_i);
            chk_bit("preset_valid", pn <= 6'h20, preset_valid_o);
        end
        rd(OFS_SET_FLAGS, 32'h1 << BIT_SET_PRESET);
        repeat (3) @(posedge clk_i);
        stop_test();
    end
endmodule

// file: tb/weld_alarm_monitor_asserts.sv
// weld_alarm_monitor_asserts: port timing checks for the alarm monitor.
// assumes it is bound to each monitor instance and sees only its ports.
`timescale 1ns/1ps
module weld_alarm_monitor_asserts
    import weld_alarm_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic          clk_i,
    input wire logic          srst_i,
    input wire logic          powerup_i,
    input wire logic          strap_short_i,
    input wire logic          weld_active_i,
    input wire logic          weld_start_i,
    input wire logic          brake_active_i,
    input wire logic [DW-1:0] current_i,
    input wire logic [DW-1:0] current_peak_i,
    input wire logic          preset_recall_i,
    input wire logic [5:0]    preset_num_i,
    input wire logic          rd_i,
    input wire logic [31:0]   rdata_o,
    input wire logic          sonics_off_o,
    input wire logic          cycle_abort_o,
    input wire logic          cold_start_o,
    input wire logic          preset_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // current at its peak limit inside the weld window
    sequence curr_hit;
        weld_active_i && !brake_active_i && current_i >= current_peak_i;
    endsequence
    // hit on the first cycle after a weld start
    sequence start_then_hit;
        weld_start_i && weld_active_i ##1 curr_hit;
    endsequence
    rdata_idle_a: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    ovl_stop_a: assert property (
        curr_hit |=> sonics_off_o)
        else $error("current overload did not stop sonics");
    ovl_abort_a: assert property (
        start_then_hit |-> ##2 cycle_abort_o)
        else $error("current overload did not abort the cycle");
    off_first_a: assert property (
        $rose(cycle_abort_o) |-> $past(sonics_off_o))
        else $error("abort came before sonics stop");
    abort_hold_a: assert property (
        cycle_abort_o && weld_active_i |=> cycle_abort_o)
        else $error("abort dropped while the weld was active");
    preset_ok_a: assert property (
        preset_recall_i && preset_num_i <= PRESET_MAX |=> preset_valid_o)
        else $error("valid preset recall not accepted");
    preset_bad_a: assert property (
        preset_recall_i && preset_num_i > PRESET_MAX |=> !preset_valid_o)
        else $error("invalid preset recall accepted");
    valid_cause_a: assert property (
        preset_valid_o |-> $past(preset_recall_i))
        else $error("preset accept without a recall");
    cold_pulse_a: assert property (
        cold_start_o |-> $past(powerup_i) && $past(strap_short_i)
            ##1 !cold_start_o)
        else $error("cold start without strap at power up");
endmodule

bind weld_alarm_monitor weld_alarm_monitor_asserts #(.DW(DW)) i_chk (.*);

// file: tb/weld_stack_model.sv
// weld_stack_model: converter stack and analog inputs facing the
// monitor; fault_i pushes one reading to or just past its limit.
// assumes fault_i changes just after a rising clock edge.
`timescale 1ns/1ps
module weld_stack_model (
    input  wire logic       req_i,
    input  wire logic       stop_i,
    input  wire logic [3:0] fault_i,
    output logic            sonics_on_o,
    output logic            phase_out_o,
    output logic     [15:0] current_o,
    output logic     [15:0] freq_o,
    output logic     [15:0] power_o,
    output logic     [15:0] voltage_o,
    output logic     [15:0] temp_o,
    output logic     [15:0] energy_o,
    output logic     [15:0] cust1_o,
    output logic     [15:0] cust2_o,
    output logic     [15:0] peak_o
);
    // the stack goes silent once the monitor has cut the sonics
    assign sonics_on_o = req_i && !stop_i;
    assign peak_o      = 16'h03E8;
    assign energy_o    = 16'h0001;
    // nominal readings sit inside every window; faults hit the edges
    always_comb begin
        phase_out_o = fault_i == 4'h6;
        current_o   = (fault_i == 4'h1) ? 16'h03E8 : 16'h0064;
        power_o     = (fault_i == 4'h2) ? 16'h03E8 :
                      (fault_i == 4'h7) ? 16'h0081 : 16'h0064;
        voltage_o   = (fault_i == 4'h3) ? 16'h03E8 : 16'h0064;
        temp_o      = (fault_i == 4'h5) ? 16'h0352 : 16'h00FA;
        cust1_o     = (fault_i == 4'h8) ? 16'h0081 : 16'h0000;
        cust2_o     = (fault_i == 4'h9) ? 16'h0081 : 16'h0000;
        case (fault_i)
            4'h4:    freq_o = 16'h4E1F; // one below the low window edge
            4'hA:    freq_o = 16'h4F9B; // one past start minus offset
            4'hB:    freq_o = 16'h5065; // one past start plus offset
            default: freq_o = 16'h5000;
        endcase
    end
endmodule
